// [verilog/cbtc_pkg.sv]
// package for the bit, transfer and control execution unit
// assumes one 25 MHz clock; decoded opcodes arrive from the core's decoder
package cbtc_pkg;
  // status word bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [15:0] SP_RST    = 16'h00FF;
  localparam logic [15:0] ONE16     = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  // pointer select codes
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  // execution cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [4:0] REG_R0 = 5'h00;
  localparam logic [4:0] REG_R1 = 5'h01;
  // low registers of the X, Y and Z pointer pairs
  localparam logic [4:0] REG_XL = 5'h1A;
  localparam logic [4:0] REG_YL = 5'h1C;
  localparam logic [4:0] REG_ZL = 5'h1E;

  // operation codes handed in by the decoder
  typedef enum logic [4:0] {
    OP_NOP        = 5'b00000,
    OP_ROT_RC     = 5'b00001,
    OP_BIT_TO_T   = 5'b00010,
    OP_T_TO_BIT   = 5'b00011,
    OP_FSET       = 5'b00100,
    OP_FCLR       = 5'b00101,
    OP_LD_IND     = 5'b00110,
    OP_LD_INC     = 5'b00111,
    OP_LD_DEC     = 5'b01000,
    OP_LD_DISP    = 5'b01001,
    OP_ST_IND     = 5'b01010,
    OP_ST_INC     = 5'b01011,
    OP_ST_DEC     = 5'b01100,
    OP_ST_DISP    = 5'b01101,
    OP_LD_DIR     = 5'b01110,
    OP_ST_DIR     = 5'b01111,
    OP_PM_R0      = 5'b10000,
    OP_PM_RD      = 5'b10001,
    OP_PM_INC     = 5'b10010,
    OP_PM_WR      = 5'b10011,
    OP_PUSH       = 5'b10100,
    OP_POP        = 5'b10101,
    OP_SLEEP      = 5'b10110,
    OP_WDOG       = 5'b10111,
    OP_MOV        = 5'b11000,
    OP_PAIR_COPY  = 5'b11001,
    OP_LOAD_IMM   = 5'b11010,
    OP_IN         = 5'b11011,
    OP_OUT        = 5'b11100
  } cbtc_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM  = 2'b01,
    ST_PM   = 2'b10,
    ST_DONE = 2'b11
  } cbtc_state_t;
endpackage : cbtc_pkg

// [verilog/cbtc_exec.sv]
// execution unit: rotate, flag, bit, memory transfer and control ops
// assumes issue is a one-cycle pulse accepted only while o_BUSY is low;
// data memory answers within the strobe cycle, program memory one after
//
// Design decisions made here: the address-and-strobe port and the register addresses.
module cbtc_exec
(
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  // decoded instruction
  input  wire logic        i_issue,
  input  wire logic [4:0]  i_op,
  input  wire logic [4:0]  i_rd,
  input  wire logic [4:0]  i_rr,
  input  wire logic [2:0]  i_bit,
  input  wire logic [1:0]  i_ptr,
  input  wire logic [15:0] i_imm,
  // memory and i/o read data
  input  wire logic [7:0]  i_dm_rdata,
  input  wire logic [15:0] i_pm_rdata,
  input  wire logic [7:0]  i_io_rdata,
  // status and control
  output logic             o_BUSY,
  output logic             o_DONE,
  output logic [7:0]       o_STATUS_WORD,
  output logic             o_SLEEP_REQ,
  output logic             o_WDOG_RESTART,
  // data memory port
  output logic             o_DM_RD,
  output logic             o_DM_WR,
  output logic [15:0]      o_DM_ADDR,
  output logic [7:0]       o_DM_WDATA,
  // program memory port
  output logic             o_PM_RD,
  output logic             o_PM_WR,
  output logic [15:0]      o_PM_ADDR,
  output logic [15:0]      o_PM_WDATA,
  // i/o space port
  output logic             o_IO_WR,
  output logic [5:0]       o_IO_ADDR,
  output logic [7:0]       o_IO_WDATA
);
  logic [7:0]            regs [32];
  logic [15:0]           sp;
  cbtc_pkg::cbtc_state_t state;
  logic                  pm_op;
  logic [4:0]            ptr_lo;
  logic [4:0]            dest;
  logic                  mem_is_pm;
  logic                  pm_hi;
  logic [7:0]            rd_val;
  logic [7:0]            rr_val;
  logic [15:0]           ptr_val;
  logic [15:0]           ptr_inc;
  logic [15:0]           ptr_dec;
  logic [7:0]            ror_res;
  cbtc_pkg::cbtc_op_t    op;

  assign op      = cbtc_pkg::cbtc_op_t'(i_op);
  assign rd_val  = regs[i_rd];
  assign rr_val  = regs[i_rr];
  assign ror_res = {o_STATUS_WORD[cbtc_pkg::FLAG_C], rd_val[7:1]};
  // program memory ops always address through Z, whatever i_ptr says
  assign pm_op   = op == cbtc_pkg::OP_PM_R0 || op == cbtc_pkg::OP_PM_RD ||
                   op == cbtc_pkg::OP_PM_INC || op == cbtc_pkg::OP_PM_WR;
  // pointer pairs live in r27:r26, r29:r28, r31:r30
  always_comb
  begin
    case (pm_op ? cbtc_pkg::PTR_Z : i_ptr)
      cbtc_pkg::PTR_X: ptr_lo = cbtc_pkg::REG_XL;
      cbtc_pkg::PTR_Y: ptr_lo = cbtc_pkg::REG_YL;
      default:         ptr_lo = cbtc_pkg::REG_ZL;
    endcase
  end
  assign ptr_val = {regs[{ptr_lo[4:1], 1'b1}], regs[ptr_lo]};
  assign ptr_inc = ptr_val + cbtc_pkg::ONE16;
  assign ptr_dec = ptr_val - cbtc_pkg::ONE16;

  // sequencer: memory ops hold busy until their last cycle
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state     <= cbtc_pkg::ST_IDLE;
      o_BUSY    <= 1'b0;
      o_DONE    <= 1'b0;
      dest      <= 5'h00;
      mem_is_pm <= 1'b0;
      pm_hi     <= 1'b0;
    end
    else
    begin
      o_DONE <= 1'b0;
      case (state)
        cbtc_pkg::ST_IDLE:
        begin
          if (i_issue)
          begin
            dest  <= (op == cbtc_pkg::OP_PM_R0) ? cbtc_pkg::REG_R0 : i_rd;
            pm_hi <= 1'b0;
            case (op)
              cbtc_pkg::OP_LD_IND, cbtc_pkg::OP_LD_INC, cbtc_pkg::OP_LD_DEC,
              cbtc_pkg::OP_LD_DISP, cbtc_pkg::OP_LD_DIR, cbtc_pkg::OP_POP,
              cbtc_pkg::OP_ST_IND, cbtc_pkg::OP_ST_INC, cbtc_pkg::OP_ST_DEC,
              cbtc_pkg::OP_ST_DISP, cbtc_pkg::OP_ST_DIR, cbtc_pkg::OP_PUSH,
              cbtc_pkg::OP_PM_WR:
              begin
                state     <= cbtc_pkg::ST_MEM;
                o_BUSY    <= 1'b1;
                mem_is_pm <= 1'b0;
              end
              cbtc_pkg::OP_PM_R0, cbtc_pkg::OP_PM_RD, cbtc_pkg::OP_PM_INC:
              begin
                state     <= cbtc_pkg::ST_PM;
                o_BUSY    <= 1'b1;
                mem_is_pm <= 1'b1;
                pm_hi     <= ptr_val[0];
              end
              default:
              begin
                o_DONE <= 1'b1;
              end
            endcase
          end
        end
        cbtc_pkg::ST_PM:
        begin
          // one wait covers the program memory latency: three clocks total
          state <= cbtc_pkg::ST_MEM;
        end
        default:
        begin
          state  <= cbtc_pkg::ST_IDLE;
          o_BUSY <= 1'b0;
          o_DONE <= 1'b1;
        end
      endcase
    end
  end

  // register file writes, pointer updates and load returns
  always_ff @(posedge I_SYS_CLK)
  begin
    if (state == cbtc_pkg::ST_MEM && !mem_is_pm && o_DM_RD)
    begin
      regs[dest] <= i_dm_rdata;
    end
    else if (state == cbtc_pkg::ST_MEM && mem_is_pm)
    begin
      regs[dest] <= pm_hi ? i_pm_rdata[15:8] : i_pm_rdata[7:0];
    end
    else if (state == cbtc_pkg::ST_IDLE && i_issue)
    begin
      case (op)
        cbtc_pkg::OP_ROT_RC: regs[i_rd] <= ror_res;
        cbtc_pkg::OP_T_TO_BIT:
        begin
          regs[i_rd][i_bit] <= o_STATUS_WORD[cbtc_pkg::FLAG_T];
        end
        cbtc_pkg::OP_MOV: regs[i_rd] <= rr_val;
        cbtc_pkg::OP_PAIR_COPY:
        begin
          regs[{i_rd[4:1], 1'b0}] <= regs[{i_rr[4:1], 1'b0}];
          regs[{i_rd[4:1], 1'b1}] <= regs[{i_rr[4:1], 1'b1}];
        end
        cbtc_pkg::OP_LOAD_IMM: regs[i_rd] <= i_imm[7:0];
        cbtc_pkg::OP_IN:  regs[i_rd] <= i_io_rdata;
        cbtc_pkg::OP_LD_INC, cbtc_pkg::OP_ST_INC, cbtc_pkg::OP_PM_INC:
        begin
          // pointer moves at issue, so a later load into it still wins
          {regs[{ptr_lo[4:1], 1'b1}], regs[ptr_lo]}
            <= ptr_inc;
        end
        cbtc_pkg::OP_LD_DEC, cbtc_pkg::OP_ST_DEC:
        begin
          {regs[{ptr_lo[4:1], 1'b1}], regs[ptr_lo]}
            <= ptr_dec;
        end
        default:
        begin
        end
      endcase
    end
  end

  // status word: only rotate, bit store and flag ops touch it
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      o_STATUS_WORD <= cbtc_pkg::STATUS_RST;
    end
    else if (state == cbtc_pkg::ST_IDLE && i_issue)
    begin
      case (op)
        cbtc_pkg::OP_ROT_RC:
        begin
          o_STATUS_WORD[cbtc_pkg::FLAG_C] <= rd_val[0];
          o_STATUS_WORD[cbtc_pkg::FLAG_Z] <= ror_res == cbtc_pkg::BYTE_ZERO;
          o_STATUS_WORD[cbtc_pkg::FLAG_N] <= ror_res[7];
          o_STATUS_WORD[cbtc_pkg::FLAG_V] <= ror_res[7] ^ rd_val[0];
        end
        cbtc_pkg::OP_BIT_TO_T:
        begin
          o_STATUS_WORD[cbtc_pkg::FLAG_T] <= rr_val[i_bit];
        end
        cbtc_pkg::OP_FSET: o_STATUS_WORD[i_bit] <= 1'b1;
        cbtc_pkg::OP_FCLR: o_STATUS_WORD[i_bit] <= 1'b0;
        default:
        begin
        end
      endcase
    end
  end

  // memory strobes and addresses, issued on the first cycle
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      o_DM_RD    <= 1'b0;
      o_DM_WR    <= 1'b0;
      o_DM_ADDR  <= cbtc_pkg::PTR_RST;
      o_DM_WDATA <= cbtc_pkg::BYTE_ZERO;
      o_PM_RD    <= 1'b0;
      o_PM_WR    <= 1'b0;
      o_PM_ADDR  <= cbtc_pkg::PTR_RST;
      o_PM_WDATA <= cbtc_pkg::PTR_RST;
      sp         <= cbtc_pkg::SP_RST;
    end
    else
    begin
      o_DM_RD <= 1'b0;
      o_DM_WR <= 1'b0;
      o_PM_RD <= 1'b0;
      o_PM_WR <= 1'b0;
      if (state == cbtc_pkg::ST_IDLE && i_issue)
      begin
        o_DM_WDATA <= rr_val;
        case (op)
          cbtc_pkg::OP_LD_IND, cbtc_pkg::OP_LD_INC:
          begin
            o_DM_RD   <= 1'b1;
            o_DM_ADDR <= ptr_val;
          end
          cbtc_pkg::OP_LD_DEC:
          begin
            o_DM_RD   <= 1'b1;
            o_DM_ADDR <= ptr_dec;
          end
          cbtc_pkg::OP_LD_DISP:
          begin
            o_DM_RD   <= 1'b1;
            o_DM_ADDR <= ptr_val + i_imm;
          end
          cbtc_pkg::OP_LD_DIR:
          begin
            o_DM_RD   <= 1'b1;
            o_DM_ADDR <= i_imm;
          end
          cbtc_pkg::OP_ST_IND, cbtc_pkg::OP_ST_INC:
          begin
            o_DM_WR   <= 1'b1;
            o_DM_ADDR <= ptr_val;
          end
          cbtc_pkg::OP_ST_DEC:
          begin
            o_DM_WR   <= 1'b1;
            o_DM_ADDR <= ptr_dec;
          end
          cbtc_pkg::OP_ST_DISP:
          begin
            o_DM_WR   <= 1'b1;
            o_DM_ADDR <= ptr_val + i_imm;
          end
          cbtc_pkg::OP_ST_DIR:
          begin
            o_DM_WR   <= 1'b1;
            o_DM_ADDR <= i_imm;
          end
          cbtc_pkg::OP_PUSH:
          begin
            o_DM_WR   <= 1'b1;
            o_DM_ADDR <= sp;
            sp        <= sp - cbtc_pkg::ONE16;
          end
          cbtc_pkg::OP_POP:
          begin
            o_DM_RD   <= 1'b1;
            o_DM_ADDR <= sp + cbtc_pkg::ONE16;
            sp        <= sp + cbtc_pkg::ONE16;
          end
          cbtc_pkg::OP_PM_R0, cbtc_pkg::OP_PM_RD, cbtc_pkg::OP_PM_INC:
          begin
            o_PM_RD   <= 1'b1;
            o_PM_ADDR <= {1'b0, ptr_val[15:1]};
          end
          cbtc_pkg::OP_PM_WR:
          begin
            o_PM_WR    <= 1'b1;
            o_PM_ADDR  <= {1'b0, ptr_val[15:1]};
            o_PM_WDATA <= {regs[cbtc_pkg::REG_R1], regs[cbtc_pkg::REG_R0]};
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // control pulses and i/o writes, one clock each
  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      o_SLEEP_REQ    <= 1'b0;
      o_WDOG_RESTART <= 1'b0;
      o_IO_WR        <= 1'b0;
      o_IO_ADDR      <= 6'h00;
      o_IO_WDATA     <= cbtc_pkg::BYTE_ZERO;
    end
    else
    begin
      o_SLEEP_REQ    <= i_issue && state == cbtc_pkg::ST_IDLE &&
                        op == cbtc_pkg::OP_SLEEP;
      o_WDOG_RESTART <= i_issue && state == cbtc_pkg::ST_IDLE &&
                        op == cbtc_pkg::OP_WDOG;
      o_IO_WR        <= i_issue && state == cbtc_pkg::ST_IDLE &&
                        op == cbtc_pkg::OP_OUT;
      o_IO_ADDR      <= i_imm[5:0];
      o_IO_WDATA     <= rr_val;
    end
  end

  // two-clock memory ops end with done two edges after issue
  mem_two_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (i_issue && !o_BUSY && op == cbtc_pkg::OP_LD_DIR) |-> ##2 o_DONE)
    else $error("direct load not two clocks");
  pm_three_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (i_issue && !o_BUSY && op == cbtc_pkg::OP_PM_RD) |->
      ##1 !o_DONE ##1 !o_DONE ##1 o_DONE)
    else $error("program read not three clocks");
  rot_carry_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (i_issue && !o_BUSY && op == cbtc_pkg::OP_ROT_RC) |=>
      o_STATUS_WORD[cbtc_pkg::FLAG_C] == $past(rd_val[0]))
    else $error("rotate carry wrong");
  bit_store_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (i_issue && !o_BUSY && op == cbtc_pkg::OP_BIT_TO_T) |=>
      o_STATUS_WORD[cbtc_pkg::FLAG_T] == $past(rr_val[i_bit]))
    else $error("bit store wrong");
  flag_set_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (i_issue && !o_BUSY && op == cbtc_pkg::OP_FSET) |=>
      o_STATUS_WORD == ($past(o_STATUS_WORD) | (8'h01 << $past(i_bit))))
    else $error("flag set touched others");
  dec_addr_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (i_issue && !o_BUSY && op == cbtc_pkg::OP_ST_DEC) |=>
      o_DM_WR && o_DM_ADDR == $past(ptr_dec))
    else $error("pre-decrement address wrong");
  sleep_pulse_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    o_SLEEP_REQ |=> !o_SLEEP_REQ)
    else $error("sleep request too long");
  wdog_a: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    (i_issue && !o_BUSY && op == cbtc_pkg::OP_WDOG) |=>
      o_WDOG_RESTART && !o_BUSY)
    else $error("watchdog restart missing");
  push_c: cover property (@(posedge I_SYS_CLK) i_issue &&
    op == cbtc_pkg::OP_PUSH);
  pm_c: cover property (@(posedge I_SYS_CLK) o_PM_RD ##2 o_DONE);
  ror_c: cover property (@(posedge I_SYS_CLK) i_issue &&
    op == cbtc_pkg::OP_ROT_RC);
endmodule : cbtc_exec

// [verif/cbtc_mem.sv]
// memory model on the far side of the execution unit
// assumes one-cycle strobes on the unit's clock; needs no reset
module cbtc_mem
(
  // clock
  input  wire logic        I_SYS_CLK,
  // data memory
  input  wire logic        i_dm_rd,
  input  wire logic        i_dm_wr,
  input  wire logic [15:0] i_dm_addr,
  input  wire logic [7:0]  i_dm_wdata,
  output logic      [7:0]  o_dm_rdata,
  // program memory
  input  wire logic        i_pm_rd,
  input  wire logic        i_pm_wr,
  input  wire logic [15:0] i_pm_addr,
  input  wire logic [15:0] i_pm_wdata,
  output logic      [15:0] o_pm_rdata,
  // i/o space
  input  wire logic        i_io_wr,
  input  wire logic [5:0]  i_io_addr,
  input  wire logic [7:0]  i_io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  dm [0:65535];
  logic [15:0] pm [0:65535];
  logic [15:0] dm_ra;
  logic [15:0] dm_wa;
  logic [15:0] pm_ra;
  logic [7:0]  io_wd;
  logic [5:0]  io_wa;
  logic [7:0]  dm_last = 8'h00;
  initial o_pm_rdata = 16'h0000;
  // data answers within the strobe cycle, where the unit samples it;
  // inverted junk outside it exposes a sample taken at the wrong edge
  assign o_dm_rdata = i_dm_rd ? dm[i_dm_addr] : ~dm_last;
  always @(posedge I_SYS_CLK)
  begin
    if (i_dm_rd) dm_last <= dm[i_dm_addr];
    if (i_dm_rd) dm_ra <= i_dm_addr;
    if (i_dm_wr) dm[i_dm_addr] <= i_dm_wdata;
    if (i_dm_wr) dm_wa <= i_dm_addr;
  end
  // program word stands in the cycle after the strobe; i/o writes logged
  always @(posedge I_SYS_CLK)
  begin
    o_pm_rdata <= i_pm_rd ? pm[i_pm_addr] : ~o_pm_rdata;
    if (i_pm_rd) pm_ra <= i_pm_addr;
    if (i_pm_wr) pm[i_pm_addr] <= i_pm_wdata;
    if (i_io_wr) io_wa <= i_io_addr;
    if (i_io_wr) io_wd <= i_io_wdata;
  end
endmodule : cbtc_mem

// [verif/testbench.sv]
// self-checking bench for the bit, transfer and control execution unit
// assumes the memory model keeps every write and answers on contract time
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", n, e, s); end end
  // design inputs
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        issue = 1'b0;
  logic [4:0]  op = 5'h00;
  logic [4:0]  rd = 5'h00;
  logic [4:0]  rr = 5'h00;
  logic [2:0]  bsel = 3'h0;
  logic [1:0]  psel = 2'h0;
  logic [15:0] imm = 16'h0000;
  logic [7:0]  io_rdata = 8'h00;
  // design outputs and bench counters
  logic        busy, done, slp, wdg, dm_rd, dm_wr, pm_rd, pm_wr, io_wr;
  logic [7:0]  status, dm_rdata, dm_wdata, io_wdata;
  logic [15:0] pm_rdata, dm_addr, pm_addr, pm_wdata;
  logic [5:0]  io_addr;
  int          err_total = 0;
  int          checked = 0;
  int          n_slp = 0;
  int          n_wdg = 0;

  always #20 sys_clk = ~sys_clk;

  cbtc_exec DUT (.I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst),
    .i_issue(issue), .i_op(op), .i_rd(rd), .i_rr(rr), .i_bit(bsel),
    .i_ptr(psel), .i_imm(imm), .i_dm_rdata(dm_rdata),
    .i_pm_rdata(pm_rdata), .i_io_rdata(io_rdata), .o_BUSY(busy),
    .o_DONE(done), .o_STATUS_WORD(status), .o_SLEEP_REQ(slp),
    .o_WDOG_RESTART(wdg), .o_DM_RD(dm_rd), .o_DM_WR(dm_wr),
    .o_DM_ADDR(dm_addr), .o_DM_WDATA(dm_wdata), .o_PM_RD(pm_rd),
    .o_PM_WR(pm_wr), .o_PM_ADDR(pm_addr), .o_PM_WDATA(pm_wdata),
    .o_IO_WR(io_wr), .o_IO_ADDR(io_addr), .o_IO_WDATA(io_wdata));

  cbtc_mem mem (.I_SYS_CLK(sys_clk), .i_dm_rd(dm_rd), .i_dm_wr(dm_wr),
    .i_dm_addr(dm_addr), .i_dm_wdata(dm_wdata), .o_dm_rdata(dm_rdata),
    .i_pm_rd(pm_rd), .i_pm_wr(pm_wr), .i_pm_addr(pm_addr),
    .i_pm_wdata(pm_wdata), .o_pm_rdata(pm_rdata), .i_io_wr(io_wr),
    .i_io_addr(io_addr), .i_io_wdata(io_wdata));

  // pulse counters; a stuck pulse would count more than once
  always @(posedge sys_clk)
  begin
    if (slp === 1'b1) n_slp++;
    if (wdg === 1'b1) n_wdg++;
  end

  // one instruction: issue for one edge, then count cycles until done
  task automatic exe(input logic [4:0] o, d, r, input logic [2:0] b,
                     input logic [1:0] p, input logic [15:0] k,
                     input int cyc);
    int n;
    @(posedge sys_clk);
    issue <= 1'b1;
    op <= o;
    rd <= d;
    rr <= r;
    bsel <= b;
    psel <= p;
    imm <= k;
    @(posedge sys_clk);
    issue <= 1'b0;
    // done of a one-clock op stands right after the taking edge
    #1;
    n = 1;
    `CHK("busy", 1'(cyc > 1), busy)
    while (done !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK("cycles", cyc, n)
  endtask : exe

  task automatic load_imm(input logic [4:0] r, input logic [7:0] k);
    exe(cbtc_pkg::OP_LOAD_IMM, r, r, 3'h0, 2'h0, {8'h00, k}, 1);
  endtask : load_imm

  // registers have no port, so read one back through a scratch store
  task automatic ckr(input logic [4:0] r, input logic [7:0] e);
    exe(cbtc_pkg::OP_ST_DIR, r, r, 3'h0, 2'h0, 16'h0200, 2);
    @(posedge sys_clk);
    #1;
    `CHK("register", e, mem.dm[16'h0200])
  endtask : ckr

  task automatic t_flags;
    logic [7:0] e;
    e = cbtc_pkg::STATUS_RST;
    `CHK("status", e, status)
    for (int i = 0; i < 16; i++)
    begin
      exe(i < 8 ? cbtc_pkg::OP_FSET : cbtc_pkg::OP_FCLR, 5'h00, 5'h00,
          3'(i), 2'h0, 16'h0000, 1);
      e[i % 8] = (i < 8);
      `CHK("status", e, status)
    end
    $display("flags test done");
  endtask : t_flags

  task automatic t_rot;
    load_imm(5'h10, 8'h81);
    exe(cbtc_pkg::OP_FSET, 0, 0, 3'h0, 2'h0, 16'h0000, 1);
    exe(cbtc_pkg::OP_ROT_RC, 5'h10, 5'h10, 3'h0, 2'h0, 16'h0000, 1);
    `CHK("status", 8'h05, status)
    ckr(5'h10, 8'hc0);
    load_imm(5'h11, 8'h01);
    exe(cbtc_pkg::OP_FCLR, 0, 0, 3'h0, 2'h0, 16'h0000, 1);
    exe(cbtc_pkg::OP_ROT_RC, 5'h11, 5'h11, 3'h0, 2'h0, 16'h0000, 1);
    `CHK("status", 8'h0b, status)
    ckr(5'h11, 8'h00);
    $display("rotate test done");
  endtask : t_rot

  task automatic t_bits;
    load_imm(5'h14, 8'h08);
    load_imm(5'h15, 8'h00);
    load_imm(5'h16, 8'hff);
    exe(cbtc_pkg::OP_BIT_TO_T, 5'h14, 5'h14, 3'h3, 2'h0, 16'h0000, 1);
    `CHK("status", 8'h4b, status)
    exe(cbtc_pkg::OP_T_TO_BIT, 5'h15, 5'h15, 3'h6, 2'h0, 16'h0000, 1);
    exe(cbtc_pkg::OP_BIT_TO_T, 5'h14, 5'h14, 3'h0, 2'h0, 16'h0000, 1);
    `CHK("status", 8'h0b, status)
    exe(cbtc_pkg::OP_T_TO_BIT, 5'h16, 5'h16, 3'h1, 2'h0, 16'h0000, 1);
    `CHK("status", 8'h0b, status)
    ckr(5'h15, 8'h40);
    ckr(5'h16, 8'hfd);
    $display("bit test done");
  endtask : t_bits

  // each pointer: post-inc, pre-dec; for y and z, displacement then keeps the pointer
  task automatic t_ptr;
    logic [4:0] lo;
    load_imm(5'h04, 8'h5c);
    load_imm(5'h05, 8'hc3);
    for (int p = 0; p < 3; p++)
    begin
      lo = 5'(26 + 2 * p);
      load_imm(lo, 8'h10);
      load_imm(lo + 5'h01, 8'h01);
      mem.dm[16'h0110] = 8'ha5;
      exe(cbtc_pkg::OP_LD_INC, 5'h02, 5'h02, 0, 2'(p), 0, 2);
      `CHK("read addr", 16'h0110, mem.dm_ra)
      exe(cbtc_pkg::OP_LD_DEC, 5'h03, 5'h03, 0, 2'(p), 0, 2);
      `CHK("read addr", 16'h0110, mem.dm_ra)
      ckr(5'h03, 8'ha5);
      exe(cbtc_pkg::OP_ST_INC, 5'h04, 5'h04, 0, 2'(p), 0, 2);
      `CHK("store data", 8'h5c, mem.dm[16'h0110])
      exe(cbtc_pkg::OP_ST_DEC, 5'h05, 5'h05, 0, 2'(p), 0, 2);
      `CHK("store data", 8'hc3, mem.dm[16'h0110])
      if (p > 0)
      begin
        exe(cbtc_pkg::OP_LD_DISP, 2, 2, 0, 2'(p), 16'h0005, 2);
        `CHK("read addr", 16'h0115, mem.dm_ra)
        exe(cbtc_pkg::OP_ST_DISP, 4, 4, 0, 2'(p), 16'h0005, 2);
        `CHK("write addr", 16'h0115, mem.dm_wa)
        exe(cbtc_pkg::OP_LD_IND, 2, 2, 0, 2'(p), 16'h0000, 2);
        `CHK("read addr", 16'h0110, mem.dm_ra)
      end
    end
    $display("pointer test done");
  endtask : t_ptr

  task automatic t_dir;
    mem.dm[16'h0123] = 8'h3c;
    exe(cbtc_pkg::OP_LD_DIR, 5'h03, 5'h03, 0, 0, 16'h0123, 2);
    `CHK("read addr", 16'h0123, mem.dm_ra)
    ckr(5'h03, 8'h3c);
    // z still points at 0x0110 after the pointer test
    exe(cbtc_pkg::OP_ST_IND, 5'h03, 5'h03, 0, 2'h2, 0, 2);
    `CHK("store data", 8'h3c, mem.dm[16'h0110])
    `CHK("status", 8'h0b, status)
    $display("direct test done");
  endtask : t_dir

  // odd z picks the high byte of the word; post-inc moves to the next low
  task automatic t_pm;
    load_imm(5'h1e, 8'h41);
    load_imm(5'h1f, 8'h00);
    mem.pm[16'h0020] = 16'hbeef;
    mem.pm[16'h0021] = 16'h1234;
    exe(cbtc_pkg::OP_PM_R0, 0, 0, 0, 0, 0, 3);
    `CHK("pm addr", 16'h0020, mem.pm_ra)
    ckr(5'h00, 8'hbe);
    exe(cbtc_pkg::OP_PM_INC, 5'h07, 5'h07, 0, 0, 0, 3);
    ckr(5'h07, 8'hbe);
    exe(cbtc_pkg::OP_PM_RD, 5'h06, 5'h06, 0, 0, 0, 3);
    ckr(5'h06, 8'h34);
    load_imm(5'h00, 8'h11);
    load_imm(5'h01, 8'h22);
    exe(cbtc_pkg::OP_PM_WR, 0, 0, 0, 0, 0, 2);
    @(posedge sys_clk);
    #1;
    `CHK("pm word", 16'h2211, mem.pm[16'h0021])
    $display("program memory test done");
  endtask : t_pm

  task automatic t_stk;
    load_imm(5'h07, 8'h5a);
    load_imm(5'h08, 8'ha7);
    exe(cbtc_pkg::OP_PUSH, 5'h07, 5'h07, 0, 0, 0, 2);
    `CHK("push addr", cbtc_pkg::SP_RST, mem.dm_wa)
    exe(cbtc_pkg::OP_PUSH, 5'h08, 5'h08, 0, 0, 0, 2);
    `CHK("push data", 8'ha7, mem.dm[16'h00fe])
    exe(cbtc_pkg::OP_POP, 5'h09, 5'h09, 0, 0, 0, 2);
    exe(cbtc_pkg::OP_POP, 5'h0a, 5'h0a, 0, 0, 0, 2);
    `CHK("pop addr", cbtc_pkg::SP_RST, mem.dm_ra)
    ckr(5'h09, 8'ha7);
    ckr(5'h0a, 8'h5a);
    `CHK("status", 8'h0b, status)
    $display("stack test done");
  endtask : t_stk

  task automatic t_ctl;
    exe(cbtc_pkg::OP_NOP, 0, 0, 0, 0, 0, 1);
    exe(cbtc_pkg::OP_SLEEP, 0, 0, 0, 0, 0, 1);
    exe(cbtc_pkg::OP_WDOG, 0, 0, 0, 0, 0, 1);
    @(posedge sys_clk);
    #1;
    `CHK("sleep pulses", 1, n_slp)
    `CHK("watchdog pulses", 1, n_wdg)
    exe(cbtc_pkg::OP_MOV, 5'h0b, 5'h03, 0, 0, 0, 1);
    ckr(5'h0b, 8'h3c);
    exe(cbtc_pkg::OP_PAIR_COPY, 5'h0c, 5'h04, 0, 0, 0, 1);
    ckr(5'h0d, 8'hc3);
    io_rdata <= 8'h77;
    exe(cbtc_pkg::OP_IN, 5'h0e, 5'h0e, 0, 0, 16'h0005, 1);
    ckr(5'h0e, 8'h77);
    exe(cbtc_pkg::OP_OUT, 5'h03, 5'h03, 0, 0, 16'h0009, 1);
    @(posedge sys_clk);
    #1;
    `CHK("io write", {6'h09, 8'h3c}, {mem.io_wa, mem.io_wd})
    `CHK("status", 8'h0b, status)
    $display("control test done");
  endtask : t_ctl

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // watchdog: the run needs under 300 cycles, allow about 10000
  initial
  begin
    #400000;
    err_total++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_flags();
    t_rot();
    t_bits();
    t_ptr();
    t_dir();
    t_pm();
    t_stk();
    t_ctl();
    end_of_test();
  end
endmodule : testbench
